// ### src/vsm_defs.vh
`ifndef VSM_DEFS_VH
`define VSM_DEFS_VH
// address layout
`define VSM_ADDR_W 32
`define VSM_VPN_LSB 12
`define VSM_SEG_HI 31
`define VSM_SEG_LO 29
// segment selectors, top three bits
`define VSM_SEG_CACHED 3'h4
`define VSM_SEG_UNCACHED 3'h5
// top two bits, top three for the direct segment
`define VSM_TOP2_USER 2'h0
`define VSM_TOP2_USER_PHYS 2'h1
`define VSM_TOP2_KMAPPED 2'h3
`define VSM_TOP3_DIRECT 3'h0
// privilege encoding
`define VSM_MODE_KERNEL 1'h0
`define VSM_MODE_USER 1'h1
// translation shutdown value after reset, base version
`define VSM_TSHUT_BASE 1'h1
`endif

// ### src/vsm_privilege_stack.v
`timescale 1ns/10ps
`include "vsm_defs.vh"
// three-deep current/previous/old privilege stack
module vsm_privilege_stack (
  clk,
  sys_rst,
  exceptionTaken,
  returnFromException,
  userMode,
  prevUserMode
);
  input wire clk;
  input wire sys_rst;
  input wire exceptionTaken;
  input wire returnFromException;
  output reg userMode;
  output reg prevUserMode;

  reg oldUserMode;

  // push on exception, pop on return; exception wins if both arrive
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      userMode <= `VSM_MODE_KERNEL;
      prevUserMode <= `VSM_MODE_KERNEL;
      oldUserMode <= `VSM_MODE_KERNEL;
    end else if (exceptionTaken) begin
      userMode <= `VSM_MODE_KERNEL;
      prevUserMode <= userMode;
      oldUserMode <= prevUserMode;
    end else if (returnFromException) begin
      userMode <= prevUserMode;
      prevUserMode <= oldUserMode;
      // vacated slot refills with user, so returns unwind towards user mode
      oldUserMode <= `VSM_MODE_USER;
    end
  end
endmodule // vsm_privilege_stack

// ### src/vsm_virtual_segment_mapper.v
`timescale 1ns/10ps
`include "vsm_defs.vh"
// Function
// - top 20 bits page number, top three segment
// - user mode accepts only bit31 clear
// - user access with bit31 set faults
// - any exception enters kernel mode
// - return restores previous or user mode
// - kernel user-segment access translates like user
// - segment 100 maps to physical 000
// - segment 100 is cacheable
// - segment 101 maps to 000, uncached
// - top bits 11 kernel-only segment
// - user segment top bits 00 become 01, base version
// - kernel mapped segment passes address unchanged, base version
// - direct segments map same in both versions
// - translation shutdown reads 1 after reset, base
module vsm_virtual_segment_mapper #(
  parameter EXTENDED_VERSION = 0
) (
  clk,
  sys_rst,
  refValid,
  virtAddr,
  exceptionTaken,
  returnFromException,
  tlbPhysFrame,
  tlbUncached,
  physValid,
  physAddr,
  cacheable,
  virtualPageNumber,
  userMode,
  addressError,
  badVirtAddr,
  translationShutdownFlag
);
  input wire clk;
  input wire sys_rst;
  input wire refValid;
  input wire [`VSM_ADDR_W-1:0] virtAddr;
  input wire exceptionTaken;
  input wire returnFromException;
  input wire [`VSM_ADDR_W-`VSM_VPN_LSB-1:0] tlbPhysFrame;
  input wire tlbUncached;
  output reg physValid;
  output reg [`VSM_ADDR_W-1:0] physAddr;
  output reg cacheable;
  output reg [`VSM_ADDR_W-`VSM_VPN_LSB-1:0] virtualPageNumber;
  output wire userMode;
  output reg addressError;
  output reg [`VSM_ADDR_W-1:0] badVirtAddr;
  output reg translationShutdownFlag;

  wire prevUserMode;
  wire [2:0] segment;
  wire userFault;
  reg [`VSM_ADDR_W-1:0] next_physAddr;
  reg next_cacheable;
  wire inCachedSeg;
  wire inUncachedSeg;
  wire inKernelOnlySeg;
  wire inUserSeg;
  wire refAccepted;
  wire refRejected;

  // notes for the next engineer:
  // - a fault always wins over translation; the result registers keep
  //   the last good translation so the bus side never sees a faulting
  //   address, only the exception side does.
  // - the reserved top megabyte of the user and kernel-only segments is
  //   not policed here; software must stay out of it.
  // - in the extended build the page lookup sits outside this block and
  //   must answer combinationally in the same cycle as the request.
  // - exception and return in one cycle: the exception wins, the return
  //   is lost, which matches the core never retiring both at once.
  // - in the base build the high physical bits carry where a reference came from, so an
  //   outside decoder can fence off kernel-only devices cheaply.
  // - the shutdown flag has no write path; it only tells software which
  //   build it runs on.
  // - everything is registered once, costing one cycle of latency but
  //   keeping the physical address free of glitches.

  // direct segments drop the selector bits; shared by both direct paths
  function [`VSM_ADDR_W-1:0] directMap;
    input [`VSM_ADDR_W-1:0] va;
    begin
      directMap = {`VSM_TOP3_DIRECT, va[`VSM_SEG_LO-1:0]};
    end
  endfunction

  // user segment has its top two bits forced to 01 so decoders can tell it apart
  function [`VSM_ADDR_W-1:0] userMap;
    input [`VSM_ADDR_W-1:0] va;
    begin
      userMap = {`VSM_TOP2_USER_PHYS, va[`VSM_SEG_HI-2:0]};
    end
  endfunction

  // top two bits select the kernel-only mapped segment
  function isKernelOnly;
    input [`VSM_ADDR_W-1:0] va;
    begin
      isKernelOnly = (va[`VSM_SEG_HI:`VSM_SEG_HI-1] == `VSM_TOP2_KMAPPED);
    end
  endfunction

  vsm_privilege_stack privStack (
    .clk(clk),
    .sys_rst(sys_rst),
    .exceptionTaken(exceptionTaken),
    .returnFromException(returnFromException),
    .userMode(userMode),
    .prevUserMode(prevUserMode)
  );

  assign segment = virtAddr[`VSM_SEG_HI:`VSM_SEG_LO];
  // segment decode, one hot among the direct and kernel-only segments
  assign inCachedSeg = (segment == `VSM_SEG_CACHED);
  assign inUncachedSeg = (segment == `VSM_SEG_UNCACHED);
  assign inKernelOnlySeg = isKernelOnly(virtAddr);
  assign inUserSeg = ~virtAddr[`VSM_SEG_HI];
  // user may only reach bit31 clear
  assign userFault = (userMode == `VSM_MODE_USER) && !inUserSeg;
  // accept or reject decided once, used by both register paths
  assign refAccepted = refValid && !userFault;
  assign refRejected = refValid && userFault;

  // combinational segment map; extended parts take frame from outside
  always @* begin
    next_physAddr = virtAddr;
    next_cacheable = 1'b1;
    if (inCachedSeg) begin
      next_physAddr = directMap(virtAddr);
      next_cacheable = 1'b1;
    end else if (inUncachedSeg) begin
      next_physAddr = directMap(virtAddr);
      next_cacheable = 1'b0;
    end else if (EXTENDED_VERSION != 0) begin
      // page-mapped path, lookup itself lives outside
      next_physAddr = {tlbPhysFrame, virtAddr[`VSM_VPN_LSB-1:0]};
      next_cacheable = ~tlbUncached;
    end else if (inKernelOnlySeg) begin
      next_physAddr = virtAddr;
    end else begin
      next_physAddr = userMap(virtAddr);
    end
  end

  // registered translation result, one cycle after the request
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      physValid <= 1'b0;
      physAddr <= {`VSM_ADDR_W{1'b0}};
      cacheable <= 1'b0;
      virtualPageNumber <= {(`VSM_ADDR_W-`VSM_VPN_LSB){1'b0}};
      addressError <= 1'b0;
      badVirtAddr <= {`VSM_ADDR_W{1'b0}};
    end else begin
      physValid <= refAccepted;
      addressError <= refRejected;
      // high bits as set by the segment map, kept for outside decoder
      if (refAccepted) begin
        physAddr <= next_physAddr;
        cacheable <= next_cacheable;
        virtualPageNumber <= virtAddr[`VSM_ADDR_W-1:`VSM_VPN_LSB];
      end
      if (refRejected) begin
        badVirtAddr <= virtAddr;
      end
    end
  end

  // flag cleared by reset on extended parts only; no writes reach it here
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      translationShutdownFlag <= (EXTENDED_VERSION == 0) ? `VSM_TSHUT_BASE : 1'b0;
    end else begin
      translationShutdownFlag <= translationShutdownFlag;
    end
  end
endmodule // vsm_virtual_segment_mapper

// ### testbench/vsm_checker.sv
`timescale 1ns/10ps
module vsm_checker (
  input wire clk, sys_rst, refValid, exceptionTaken, userMode,
  input wire physValid, cacheable, addressError, translationShutdownFlag,
  input wire [31:0] virtAddr, physAddr, badVirtAddr,
  input wire [19:0] virtualPageNumber
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // kernel reference taken this edge
  wire k = refValid && !userMode;
  sequence s_ok; physValid && !addressError; endsequence
  property p_c0; k && virtAddr[31:29]==3'h4 |=> s_ok ##0 cacheable && physAddr=={3'h0,$past(virtAddr[28:0])};
  endproperty
  property p_c1; k && virtAddr[31:29]==3'h5 |=> s_ok ##0 !cacheable && physAddr=={3'h0,$past(virtAddr[28:0])};
  endproperty
  property p_us; refValid && !virtAddr[31] |=> s_ok ##0 physAddr=={2'h1,$past(virtAddr[29:0])}; endproperty
  property p_km; k && virtAddr[31:30]==2'h3 |=> s_ok ##0 physAddr==$past(virtAddr); endproperty
  property p_ae; refValid && userMode && virtAddr[31] |=> addressError && !physValid && badVirtAddr==$past(virtAddr);
  endproperty
  property p_pn; physValid |-> virtualPageNumber==$past(virtAddr[31:12]); endproperty
  property p_ex; exceptionTaken |=> !userMode; endproperty
  property p_ts; translationShutdownFlag; endproperty
  a_c0: assert property (p_c0) else $error("seg4");
  a_c1: assert property (p_c1) else $error("seg5");
  a_us: assert property (p_us) else $error("user");
  a_km: assert property (p_km) else $error("kmap");
  a_ae: assert property (p_ae) else $error("fault");
  a_pn: assert property (p_pn) else $error("page");
  a_ex: assert property (p_ex) else $error("mode");
  a_ts: assert property (p_ts) else $error("flag");
endmodule // vsm_checker
bind vsm_virtual_segment_mapper vsm_checker u_chk (.*);

// ### testbench/vsm_core_model.sv
`timescale 1ns/10ps
module vsm_core_model (
  input wire clk, go,
  input wire [31:0] addr,
  output reg refValid = 1'h0,
  output reg [31:0] virtAddr = 32'h0
);
  // idle address flips so a stale one never looks held
  always @(posedge clk) begin
    refValid <= go;
    virtAddr <= go ? addr : ~virtAddr;
  end
endmodule // vsm_core_model

// ### testbench/test_virtual_segment_mapper.sv
`timescale 1ns/10ps
module test_virtual_segment_mapper;
  localparam [127:0] VA = {32'hC0000000, 32'h00000010, 32'hA0000010, 32'h80001234};
  localparam [127:0] PA = {32'hC0000000, 32'h40000010, 32'h00000010, 32'h00001234};
  reg clk = 0, sys_rst = 1, go = 0, ex = 0, rf = 0;
  reg [31:0] a = 0;
  wire rv, pv, ca, um, ae, ts;
  wire [31:0] va, pa, bv;
  integer miscompares = 0, checked = 0, i;
  always #5 clk = ~clk;
  vsm_core_model core_u (.clk(clk), .go(go), .addr(a), .refValid(rv), .virtAddr(va));
  vsm_virtual_segment_mapper dut_u (.clk(clk), .sys_rst(sys_rst), .refValid(rv), .virtAddr(va),
    .exceptionTaken(ex), .returnFromException(rf), .tlbPhysFrame(20'h0), .tlbUncached(1'h0),
    .physValid(pv), .physAddr(pa), .cacheable(ca), .virtualPageNumber(),
    .userMode(um), .addressError(ae), .badVirtAddr(bv), .translationShutdownFlag(ts));
  task chk(input [31:0] s, e);
    begin
      checked = checked + 1;
      if (s !== e) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0t %h %h", $time, s, e);
      end
    end
  endtask
  // back-to-back references, answers lag two edges
  task t_map;
    for (i = 0; i < 7; i = i + 1) begin
      @(posedge clk);
      go <= i < 4;
      a <= VA[(i%4)*32 +: 32];
      #1;
      if (i > 1 && i < 6) begin
        chk(pv, 1);
        chk(pa, PA[(i-2)*32 +: 32]);
        chk(ca, i != 3);
      end
      if (i == 6) chk(pv, 0);
    end
    $display("map done");
  endtask
  task t_mode;
    begin
      @(posedge clk) ex <= 1;
      @(posedge clk) ex <= 0;
      @(posedge clk) rf <= 1;
      @(posedge clk) rf <= 0;
      #1 chk(um, 0);
      chk(ts, 1);
      chk(ae, 0);
      $display("mode done");
    end
  endtask
  // two more returns reach user mode, then a good and a faulting reference
  task t_user;
    begin
      repeat (2) begin
        @(posedge clk) rf <= 1;
        @(posedge clk) rf <= 0;
      end
      #1 chk(um, 1);
      @(posedge clk);
      go <= 1;
      a <= 32'h00000010;
      @(posedge clk) a <= 32'h80000000;
      @(posedge clk) go <= 0;
      #1 chk(pv, 1);
      chk(pa, 32'h40000010);
      chk(pa[31:30], 2'h1);
      @(posedge clk);
      #1 chk(ae, 1);
      chk(pv, 0);
      chk(bv, 32'h80000000);
      chk(pa, 32'h40000010);
      @(posedge clk) ex <= 1;
      @(posedge clk) ex <= 0;
      #1 chk(um, 0);
      $display("user done");
    end
  endtask
  task summarize;
    begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 0;
    t_map;
    t_mode;
    t_user;
    summarize;
  end
  // watchdog, tests need under 80 cycles
  initial begin
    #3000;
    miscompares = miscompares + 1;
    summarize;
  end
endmodule // test_virtual_segment_mapper
